// *** logic/ptc_pkg.sv ***
// constants, field layouts and carrier types of the pause frame transmit control block
//
// What this block does
// [RULE1] a set request bit makes the block send a pause frame with that index's quanta
// [RULE2] request index 8 sends a global frame, indices 0 to 7 priority frames
// [RULE3] resend pulse retransmits every index with its request and transmit enable set, once the frame in flight ends
// [RULE4] resend pulse also restarts every retransmission counter
// [RULE5] software pulses resend for one cycle per request, never holds it
// [RULE6] nine 16-bit quanta, entry 8 global, entries 0 to 7 per priority
// [RULE7] nine 16-bit refresh times set the retransmission interval per index
// [RULE8] global frames take destination and source from their own 48-bit settings
// [RULE9] global frames take ethertype and opcode from their own 16-bit settings
// [RULE10] priority frames take destination and source from a separate 48-bit pair
// [RULE11] priority frames take ethertype and opcode from a separate 16-bit pair
// [RULE12] a sent frame pulses its bit of pause_sent and sets it in the sticky nine-bit sent status, bit 8 global
// [RULE13] the nine-bit transmit enable gates frame transmission per index
// [RULE14] the receive enable gates only quanta toward the receive user side
// [RULE15] an asserted unsent request stays pending until its frame has gone out
package ptc_pkg;

  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  localparam int          NUM_IDX    = 9;
  localparam int          GLOBAL_IDX = 8;
  localparam logic [3:0]  GLOBAL_SEL = 4'h8;
  localparam logic [3:0]  SLOT_COUNT = 4'h9;

  // ---------------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_TX_EN    = 8'h00;
  localparam logic [7:0] OFF_RX_EN    = 8'h04;
  localparam logic [7:0] OFF_REQ      = 8'h08;
  localparam logic [7:0] OFF_RESEND   = 8'h0c;
  localparam logic [7:0] OFF_SENT     = 8'h10;
  localparam logic [7:0] OFF_PENDING  = 8'h14;
  localparam logic [7:0] OFF_G_TYPE   = 8'h18;
  localparam logic [7:0] OFF_C_TYPE   = 8'h1c;
  localparam logic [7:0] OFF_G_DA_LO  = 8'h20;
  localparam logic [7:0] OFF_G_DA_HI  = 8'h24;
  localparam logic [7:0] OFF_G_SA_LO  = 8'h28;
  localparam logic [7:0] OFF_G_SA_HI  = 8'h2c;
  localparam logic [7:0] OFF_C_DA_LO  = 8'h30;
  localparam logic [7:0] OFF_C_DA_HI  = 8'h34;
  localparam logic [7:0] OFF_C_SA_LO  = 8'h38;
  localparam logic [7:0] OFF_C_SA_HI  = 8'h3c;
  localparam logic [7:0] OFF_SLOT     = 8'h40;   // slot i at OFF_SLOT + 4*i, i = 0..8

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int ETYPE_LSB   = 0;
  localparam int OPCODE_LSB  = 16;
  localparam int QUANTA_LSB  = 0;
  localparam int REFRESH_LSB = 16;
  localparam int RESEND_BIT  = 0;
  localparam int ADDR_LO_W   = 32;
  localparam int ADDR_HI_W   = 16;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [8:0]  RST_EN       = 9'h000;
  localparam logic [15:0] RST_ETHTYPE  = 16'h8808;
  localparam logic [15:0] RST_G_OPCODE = 16'h0001;
  localparam logic [15:0] RST_C_OPCODE = 16'h0101;
  localparam logic [47:0] RST_DEST     = 48'h0180c2000001;
  localparam logic [47:0] RST_SRC      = 48'h000000000000;
  localparam logic [15:0] RST_QUANTA   = 16'hffff;
  localparam logic [15:0] RST_REFRESH  = 16'h0000;   // zero turns periodic refresh off

  // ---------------------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [47:0] dest;
    logic [47:0] src;
    logic [15:0] ethertype;
    logic [15:0] opcode;
  } ptc_hdr_t;

  typedef struct packed {
    ptc_hdr_t    hdr;
    logic [7:0]  class_vector;   // one-hot priority, zero for a global frame
    logic [15:0] quanta;
    logic        is_global;
  } ptc_frame_t;

  typedef enum logic [0:0] {
    PTC_IDLE  = 1'b0,
    PTC_OFFER = 1'b1
  } ptc_state_t;

endpackage

// *** logic/ptc_pause_slot.sv ***
// one request index: refresh timer and pending flag
`timescale 1ns/1ps
module ptc_pause_slot (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        req,
  input  wire logic        enable,
  input  wire logic        resend,
  input  wire logic [15:0] refresh,
  input  wire logic        sent,
  output logic             pending
);

  logic        active;
  logic        rise;
  logic        expire;
  logic        reload;
  logic        req_d_reg;
  logic        pending_reg;
  logic        pending_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] reload_val;

  // ---------------------------------------------------------------------------
  // timer and pending decisions
  // ---------------------------------------------------------------------------
  assign active     = req & enable;                                     // [RULE13]
  assign rise       = active & ~req_d_reg;                              // [RULE1]
  // refresh of zero never expires, so a held request is sent just once
  assign expire     = active & req_d_reg & (refresh != '0) & (count_reg == '0);  // [RULE7]
  assign reload     = rise | resend | sent | expire | ~active;          // [RULE4]
  assign reload_val = (refresh == '0) ? '0 : 16'(refresh - 16'h0001);
  assign count_next = reload ? reload_val : 16'(count_reg - 16'h0001);

  // set wins over the clear from a frame leaving in the same cycle
  assign pending_next = ~active ? 1'b0 :
                        (rise | expire | resend) ? 1'b1 :               // [RULE3]
                        sent ? 1'b0 : pending_reg;                      // [RULE15]
  assign pending      = pending_reg;

  // state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_d_reg   <= 1'b0;
      pending_reg <= 1'b0;
      count_reg   <= '0;
    end else begin
      req_d_reg   <= active;
      pending_reg <= pending_next;
      count_reg   <= count_next;
    end
  end

endmodule

// *** logic/ptc_pause_tx_ctrl.sv ***
// pause frame transmit control with apb register file
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
module ptc_pause_tx_ctrl (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    frame_valid,
  input  wire logic               frame_ready,
  output ptc_pkg::ptc_frame_t     frame_data,
  output logic      [8:0]         pause_sent,
  input  wire logic [8:0]         rx_pause_seen,
  output logic      [8:0]         rx_user_pause
);

  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  logic [8:0]          tx_en_reg;
  logic [8:0]          rx_en_reg;
  logic [8:0]          req_reg;
  logic                resend_reg;
  logic [8:0]          sent_sts_reg;
  logic [8:0]          sent_sts_next;
  ptc_pkg::ptc_hdr_t   g_hdr_reg;
  ptc_pkg::ptc_hdr_t   c_hdr_reg;
  logic [15:0]         quanta_reg  [ptc_pkg::NUM_IDX];
  logic [15:0]         refresh_reg [ptc_pkg::NUM_IDX];
  logic [31:0]         prdata_reg;
  logic [31:0]         prdata_next;
  logic                pslverr_reg;
  ptc_pkg::ptc_state_t state_reg;
  ptc_pkg::ptc_state_t state_next;
  logic [3:0]          sel_idx_reg;
  ptc_pkg::ptc_frame_t frame_reg;
  ptc_pkg::ptc_frame_t frame_next;
  logic [8:0]          sent_pulse_reg;
  logic [8:0]          rx_user_reg;

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------
  logic       setup_phase;
  logic       wr_access;
  logic [3:0] slot_idx;
  logic       slot_hit;
  logic       aligned;
  logic       known;
  logic       wr_tx_en;
  logic       wr_rx_en;
  logic       wr_req;
  logic       wr_resend;
  logic       wr_sent;
  logic       wr_g_type;
  logic       wr_c_type;
  logic       wr_g_da_lo;
  logic       wr_g_da_hi;
  logic       wr_g_sa_lo;
  logic       wr_g_sa_hi;
  logic       wr_c_da_lo;
  logic       wr_c_da_hi;
  logic       wr_c_sa_lo;
  logic       wr_c_sa_hi;
  logic       wr_slot;

  // one setup cycle, then a single access cycle: the slave never stalls
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite;
  assign slot_idx    = paddr[5:2];
  assign aligned     = (paddr[1:0] == 2'b00);
  assign slot_hit    = aligned & (paddr[7:6] == ptc_pkg::OFF_SLOT[7:6])
                       & (slot_idx < ptc_pkg::SLOT_COUNT);
  assign known       = slot_hit | (aligned & (paddr < ptc_pkg::OFF_SLOT));

  // write strobes, one per register
  assign wr_tx_en   = wr_access & (paddr == ptc_pkg::OFF_TX_EN);
  assign wr_rx_en   = wr_access & (paddr == ptc_pkg::OFF_RX_EN);
  assign wr_req     = wr_access & (paddr == ptc_pkg::OFF_REQ);
  assign wr_resend  = wr_access & (paddr == ptc_pkg::OFF_RESEND);
  assign wr_sent    = wr_access & (paddr == ptc_pkg::OFF_SENT);
  assign wr_g_type  = wr_access & (paddr == ptc_pkg::OFF_G_TYPE);
  assign wr_c_type  = wr_access & (paddr == ptc_pkg::OFF_C_TYPE);
  assign wr_g_da_lo = wr_access & (paddr == ptc_pkg::OFF_G_DA_LO);
  assign wr_g_da_hi = wr_access & (paddr == ptc_pkg::OFF_G_DA_HI);
  assign wr_g_sa_lo = wr_access & (paddr == ptc_pkg::OFF_G_SA_LO);
  assign wr_g_sa_hi = wr_access & (paddr == ptc_pkg::OFF_G_SA_HI);
  assign wr_c_da_lo = wr_access & (paddr == ptc_pkg::OFF_C_DA_LO);
  assign wr_c_da_hi = wr_access & (paddr == ptc_pkg::OFF_C_DA_HI);
  assign wr_c_sa_lo = wr_access & (paddr == ptc_pkg::OFF_C_SA_LO);
  assign wr_c_sa_hi = wr_access & (paddr == ptc_pkg::OFF_C_SA_HI);
  assign wr_slot    = wr_access & slot_hit;

  // ---------------------------------------------------------------------------
  // per-index slots
  // ---------------------------------------------------------------------------
  logic [8:0] pending;
  logic [8:0] eligible;
  logic [8:0] sent_vec;
  logic       accept;

  genvar gi;
  generate
    for (gi = 0; gi < ptc_pkg::NUM_IDX; gi++) begin : g_slot
      ptc_pause_slot u_slot (
        .pclk    (pclk),
        .presetn (presetn),
        .req     (req_reg[gi]),                                         // [RULE1]
        .enable  (tx_en_reg[gi]),                                       // [RULE13]
        .resend  (resend_reg),                                          // [RULE3]
        .refresh (refresh_reg[gi]),                                     // [RULE7]
        .sent    (sent_vec[gi]),                                        // [RULE15]
        .pending (pending[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // frame selection: global first, then the lowest priority index
  // ---------------------------------------------------------------------------
  logic [3:0]        pick_idx;
  logic              pick_global;
  ptc_pkg::ptc_hdr_t pick_hdr;

  assign eligible = pending & tx_en_reg;                                // [RULE13]

  always_comb begin
    pick_idx = '0;
    for (int i = ptc_pkg::GLOBAL_IDX - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        pick_idx = 4'(i);
      end
    end
    if (eligible[ptc_pkg::GLOBAL_IDX]) begin
      pick_idx = ptc_pkg::GLOBAL_SEL;                                   // [RULE2]
    end
  end

  assign pick_global = (pick_idx == ptc_pkg::GLOBAL_SEL);
  // global and priority frames keep fully separate header settings
  assign pick_hdr    = pick_global ? g_hdr_reg : c_hdr_reg;             // [RULE8] [RULE9] [RULE10] [RULE11]

  // frame descriptor built at selection time
  always_comb begin
    frame_next              = frame_reg;
    frame_next.hdr          = pick_hdr;
    frame_next.class_vector = pick_global ? 8'h00 : 8'(8'h01 << pick_idx[2:0]);  // [RULE2]
    frame_next.quanta       = quanta_reg[pick_idx];                     // [RULE6]
    frame_next.is_global    = pick_global;
  end

  // ---------------------------------------------------------------------------
  // offer state machine toward the mac transmit path
  // ---------------------------------------------------------------------------
  // the mac raises frame_ready only between packets, so a frame never cuts one
  assign accept   = (state_reg == ptc_pkg::PTC_OFFER) & frame_ready;    // [RULE3]
  assign sent_vec = accept ? 9'(9'h001 << sel_idx_reg) : 9'h000;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ptc_pkg::PTC_IDLE: begin
        if (|eligible) begin
          state_next = ptc_pkg::PTC_OFFER;                              // [RULE1]
        end
      end
      ptc_pkg::PTC_OFFER: begin
        if (frame_ready) begin
          state_next = ptc_pkg::PTC_IDLE;
        end
      end
      default: begin
        state_next = ptc_pkg::PTC_IDLE;
      end
    endcase
  end

  // descriptor is frozen while offered so the mac sees stable fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ptc_pkg::PTC_IDLE;
      sel_idx_reg    <= '0;
      frame_reg      <= '0;
      sent_pulse_reg <= '0;
    end else begin
      state_reg      <= state_next;
      sent_pulse_reg <= sent_vec;                                       // [RULE12]
      if ((state_reg == ptc_pkg::PTC_IDLE) && (|eligible)) begin
        sel_idx_reg <= pick_idx;
        frame_reg   <= frame_next;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // receive side gating
  // ---------------------------------------------------------------------------
  // only the user-facing quanta indication is gated; rx processing runs anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_user_reg <= '0;
    end else begin
      rx_user_reg <= rx_pause_seen & rx_en_reg;                         // [RULE14]
    end
  end

  // ---------------------------------------------------------------------------
  // sent status, sticky, write one to clear
  // ---------------------------------------------------------------------------
  // a new frame leaving in the clearing cycle keeps its bit set
  assign sent_sts_next = (sent_sts_reg & ~(wr_sent ? pwdata[8:0] : 9'h000)) | sent_vec;  // [RULE12]

  // ---------------------------------------------------------------------------
  // control and header registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_reg    <= ptc_pkg::RST_EN;
      rx_en_reg    <= ptc_pkg::RST_EN;
      req_reg      <= '0;
      resend_reg   <= 1'b0;
      sent_sts_reg <= '0;
    end else begin
      sent_sts_reg <= sent_sts_next;
      // self-clearing, so the resend pulse lasts exactly one cycle
      resend_reg   <= wr_resend & pwdata[ptc_pkg::RESEND_BIT];          // [RULE5] [RULE4]
      if (wr_tx_en) begin
        tx_en_reg <= pwdata[8:0];                                       // [RULE13]
      end
      if (wr_rx_en) begin
        rx_en_reg <= pwdata[8:0];
      end
      if (wr_req) begin
        req_reg <= pwdata[8:0];                                         // [RULE1]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      g_hdr_reg <= '{dest: ptc_pkg::RST_DEST, src: ptc_pkg::RST_SRC,
                     ethertype: ptc_pkg::RST_ETHTYPE, opcode: ptc_pkg::RST_G_OPCODE};
      c_hdr_reg <= '{dest: ptc_pkg::RST_DEST, src: ptc_pkg::RST_SRC,
                     ethertype: ptc_pkg::RST_ETHTYPE, opcode: ptc_pkg::RST_C_OPCODE};
    end else begin
      if (wr_g_type) begin
        g_hdr_reg.ethertype <= pwdata[ptc_pkg::ETYPE_LSB +: 16];        // [RULE9]
        g_hdr_reg.opcode    <= pwdata[ptc_pkg::OPCODE_LSB +: 16];
      end
      if (wr_c_type) begin
        c_hdr_reg.ethertype <= pwdata[ptc_pkg::ETYPE_LSB +: 16];        // [RULE11]
        c_hdr_reg.opcode    <= pwdata[ptc_pkg::OPCODE_LSB +: 16];
      end
      if (wr_g_da_lo) g_hdr_reg.dest[31:0]  <= pwdata;                  // [RULE8]
      if (wr_g_da_hi) g_hdr_reg.dest[47:32] <= pwdata[15:0];
      if (wr_g_sa_lo) g_hdr_reg.src[31:0]   <= pwdata;
      if (wr_g_sa_hi) g_hdr_reg.src[47:32]  <= pwdata[15:0];
      if (wr_c_da_lo) c_hdr_reg.dest[31:0]  <= pwdata;                  // [RULE10]
      if (wr_c_da_hi) c_hdr_reg.dest[47:32] <= pwdata[15:0];
      if (wr_c_sa_lo) c_hdr_reg.src[31:0]   <= pwdata;
      if (wr_c_sa_hi) c_hdr_reg.src[47:32]  <= pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------------------
  // quanta and refresh table, one word per index
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ptc_pkg::NUM_IDX; i++) begin
        quanta_reg[i]  <= ptc_pkg::RST_QUANTA;
        refresh_reg[i] <= ptc_pkg::RST_REFRESH;
      end
    end else if (wr_slot) begin
      quanta_reg[slot_idx]  <= pwdata[ptc_pkg::QUANTA_LSB +: 16];       // [RULE6]
      refresh_reg[slot_idx] <= pwdata[ptc_pkg::REFRESH_LSB +: 16];      // [RULE7]
    end
  end

  // ---------------------------------------------------------------------------
  // read mux, sampled in the setup cycle
  // ---------------------------------------------------------------------------
  always_comb begin
    prdata_next = '0;
    if (slot_hit) begin
      prdata_next = {refresh_reg[slot_idx], quanta_reg[slot_idx]};
    end else if (paddr == ptc_pkg::OFF_TX_EN) begin
      prdata_next = {23'h000000, tx_en_reg};
    end else if (paddr == ptc_pkg::OFF_RX_EN) begin
      prdata_next = {23'h000000, rx_en_reg};
    end else if (paddr == ptc_pkg::OFF_REQ) begin
      prdata_next = {23'h000000, req_reg};
    end else if (paddr == ptc_pkg::OFF_SENT) begin
      prdata_next = {23'h000000, sent_sts_reg};
    end else if (paddr == ptc_pkg::OFF_PENDING) begin
      prdata_next = {23'h000000, pending};
    end else if (paddr == ptc_pkg::OFF_G_TYPE) begin
      prdata_next = {g_hdr_reg.opcode, g_hdr_reg.ethertype};
    end else if (paddr == ptc_pkg::OFF_C_TYPE) begin
      prdata_next = {c_hdr_reg.opcode, c_hdr_reg.ethertype};
    end else if (paddr == ptc_pkg::OFF_G_DA_LO) begin
      prdata_next = g_hdr_reg.dest[31:0];
    end else if (paddr == ptc_pkg::OFF_G_DA_HI) begin
      prdata_next = {16'h0000, g_hdr_reg.dest[47:32]};
    end else if (paddr == ptc_pkg::OFF_G_SA_LO) begin
      prdata_next = g_hdr_reg.src[31:0];
    end else if (paddr == ptc_pkg::OFF_G_SA_HI) begin
      prdata_next = {16'h0000, g_hdr_reg.src[47:32]};
    end else if (paddr == ptc_pkg::OFF_C_DA_LO) begin
      prdata_next = c_hdr_reg.dest[31:0];
    end else if (paddr == ptc_pkg::OFF_C_DA_HI) begin
      prdata_next = {16'h0000, c_hdr_reg.dest[47:32]};
    end else if (paddr == ptc_pkg::OFF_C_SA_LO) begin
      prdata_next = c_hdr_reg.src[31:0];
    end else if (paddr == ptc_pkg::OFF_C_SA_HI) begin
      prdata_next = {16'h0000, c_hdr_reg.src[47:32]};
    end
  end

  // read data and error are registered so the access phase sees flop outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg  <= pwrite ? 32'h00000000 : prdata_next;
      pslverr_reg <= ~known;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign prdata        = prdata_reg;
  assign pslverr       = pslverr_reg & psel & penable;
  assign pready        = 1'b1;                  // zero wait states
  assign frame_valid   = (state_reg == ptc_pkg::PTC_OFFER);
  assign frame_data    = frame_reg;
  assign pause_sent    = sent_pulse_reg;        // [RULE12]
  assign rx_user_pause = rx_user_reg;

endmodule

// *** verification/ptc_pause_tx_ctrl_assertions.sv ***
// checker watching the pause frame transmit controller ports
`timescale 1ns/1ps
module ptc_chk (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                frame_valid,
  input wire logic                frame_ready,
  input wire ptc_pkg::ptc_frame_t frame_data,
  input wire logic [8:0]          pause_sent,
  input wire logic [8:0]          rx_pause_seen,
  input wire logic [8:0]          rx_user_pause
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // index bits named by the offered descriptor
  wire [8:0] idx_w = {frame_data.is_global, frame_data.class_vector};
  sequence acc_s; frame_valid && frame_ready; endsequence
  sequence stall_s; frame_valid && !frame_ready; endsequence
  hold_frame_a: assert property (stall_s |=> frame_valid && $stable(frame_data))
    else $error("frame withdrawn before accept");
  sent_bit_a: assert property (acc_s |=> pause_sent == $past(idx_w))
    else $error("sent pulse does not match frame");
  sent_cause_a: assert property (pause_sent != 9'h000 |-> $past(frame_valid && frame_ready))
    else $error("sent pulse without accept");
  sent_single_a: assert property (pause_sent != 9'h000 |=> pause_sent == 9'h000)
    else $error("sent pulse longer than one cycle");
  idle_gap_a: assert property (acc_s |=> !frame_valid)
    else $error("no idle cycle after accept");
  global_kind_a: assert property (frame_valid && frame_data.is_global |-> !frame_data.class_vector)
    else $error("global frame carries a class");
  class_kind_a: assert property (frame_valid && !frame_data.is_global |-> $onehot(frame_data.class_vector))
    else $error("priority frame not one class");
  rx_gate_a: assert property (rx_user_pause != 9'h000 |-> !(rx_user_pause & ~$past(rx_pause_seen)))
    else $error("receive quanta without cause");
endmodule
bind ptc_pause_tx_ctrl ptc_chk u_chk (.pclk(pclk), .presetn(presetn),
  .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_data(frame_data),
  .pause_sent(pause_sent), .rx_pause_seen(rx_pause_seen), .rx_user_pause(rx_user_pause));

// *** verification/ptc_mac_model.sv ***
// mac side model: takes pause frame descriptors and may stall
`timescale 1ns/1ps
module ptc_mac_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                frame_valid,
  input  wire ptc_pkg::ptc_frame_t frame_data,
  input  wire logic                stall,
  output logic                     frame_ready,
  output ptc_pkg::ptc_frame_t      last_frame,
  output logic [7:0]               frame_count
);
  // busy with its own packet while stalled, so the pause frame must wait
  assign frame_ready = !stall;
  // keep the last accepted descriptor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_count <= 8'h00;
      last_frame  <= '0;
    end else if (frame_valid && frame_ready) begin
      frame_count <= frame_count + 8'h01;
      last_frame  <= frame_data;
    end
  end
endmodule

// *** verification/test_pause_frame_tx_control.sv ***
// testbench for the pause frame transmit controller
`timescale 1ns/1ps
module test_pause_frame_tx_control;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, e;
  logic                frame_valid, frame_ready;
  logic [7:0]          paddr, fcnt;
  logic [31:0]         pwdata, prdata, q;
  logic [8:0]          pause_sent, rx_pause_seen, rx_user_pause;
  ptc_pkg::ptc_frame_t frame_data, last_frame;
  int                  fails, cmp_count, n;
  ptc_pause_tx_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .frame_data(frame_data), .pause_sent(pause_sent), .rx_pause_seen(rx_pause_seen),
    .rx_user_pause(rx_user_pause));
  ptc_mac_model mac (.pclk(pclk), .presetn(presetn), .frame_valid(frame_valid),
    .frame_data(frame_data), .stall(stall), .frame_ready(frame_ready),
    .last_frame(last_frame), .frame_count(fcnt));
  always #12.5 pclk = ~pclk;
  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // one apb transfer: idle edge, setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic err);
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", x, q);
    chk("pslverr", err, e);
  endtask
  task automatic wait_frame(input logic [7:0] k);
    for (n = 0; n < 300 && fcnt !== k; n++) @(posedge pclk);
    chk("frame count", k, fcnt);
  endtask
  task automatic chk_frame(input logic [8:0] i, input logic [15:0] q, input logic [47:0] da,
                           input logic [47:0] sa, input logic [31:0] ty);
    chk("kind", i, {last_frame.is_global, last_frame.class_vector});
    chk("quanta", q, last_frame.quanta);
    chk("dest", da, last_frame.hdr.dest);
    chk("src", sa, last_frame.hdr.src);
    chk("type", ty, {last_frame.hdr.opcode, last_frame.hdr.ethertype});
  endtask
  task automatic t_global();
    rd(8'h18, 32'h00018808, 1'b0);
    rd(8'h1c, 32'h01018808, 1'b0);
    rd(8'h64, 32'h0, 1'b1);
    wr(8'h20, 32'h33445566);
    wr(8'h24, 32'h1122);
    wr(8'h2c, 32'h0e0f);
    wr(8'h18, 32'h00058899);
    wr(8'h60, 32'h1234);
    wr(8'h00, 32'h1df);
    wr(8'h08, 32'h120);
    wait_frame(8'h01);
    chk_frame(9'h100, 16'h1234, 48'h112233445566, 48'h0e0f00000000, 32'h00058899);
    repeat (40) @(posedge pclk);
    chk("gated", 8'h01, fcnt);
    rd(8'h10, 32'h100, 1'b0);
    wr(8'h10, 32'h100);
    rd(8'h10, 32'h0, 1'b0);
    wr(8'h08, 32'h0);
  endtask
  // slow mac first, then resend and refresh on a held priority request
  task automatic t_class();
    stall <= 1'b1;
    wr(8'h00, 32'h1ff);
    wr(8'h30, 32'h77665544);
    wr(8'h1c, 32'h0101aaaa);
    wr(8'h4c, 32'h0a03);
    wr(8'h08, 32'h008);
    repeat (12) @(posedge pclk);
    chk("held", 2'b11, {frame_valid, fcnt == 8'h01});
    rd(8'h14, 32'h008, 1'b0);
    stall <= 1'b0;
    wait_frame(8'h02);
    chk_frame(9'h008, 16'h0a03, 48'h018077665544, 48'h0, 32'h0101aaaa);
    repeat (30) @(posedge pclk);
    chk("single", 8'h02, fcnt);
    wr(8'h4c, 32'h00140a03);
    wr(8'h0c, 32'h1);
    wait_frame(8'h03);
    wait_frame(8'h04);
    chk("refresh gap", 1'b1, n >= 20 && n <= 40);
    wr(8'h08, 32'h0);
  endtask
  task automatic t_rx();
    wr(8'h04, 32'h005);
    rx_pause_seen <= 9'h007;
    @(posedge pclk);
    rx_pause_seen <= 9'h000;
    @(negedge pclk);
    chk("rx quanta", 9'h005, rx_user_pause);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    stop_test();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, stall, paddr, pwdata, rx_pause_seen} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_global();
    t_class();
    t_rx();
    stop_test();
  end
endmodule
